// >>> multipurpose_io_config.sv
`timescale 1ns/1ns
/*
  Multi-purpose pin configuration block: pin configuration register,
  local control bits, pin overrides, wake-event input and the
  power-down filter timer.
  Assumes register writes come from the host bus or the EEPROM loader,
  both synchronous to CLK.
*/
// What this block does
// - Each pin's 2-bit field picks plain input, inverted input, output low or output high.
// - The configuration register holds pin n's field at bits 2n+1 to 2n.
// - Pin 0 follows its field only when device mode is not 001 or 101, else it is a forced output.
// - Pin 1 follows its field only when the filter setting is 00, else it is a forced output.
// - With the wake-enable bit set, pin 2 is a wake-event input; the low bit of its field (bit 4) sets the active level.
// - An active wake event sets a sticky status bit for function 1 that stays until cleared.
// - The wake-enable bit lets pin 2 set that status when 1 and blocks it when 0.
// - The filter setting encodes 00 off, 01 four seconds, 10 129 seconds, 11 518 seconds.
module multipurpose_io_config
  import mpio_pkg::*;
#(
  parameter int TICK_CYCLES = CLK_HZ
)
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  // Host register port
  input  wire logic                REG_SEL,
  input  wire logic                REG_WR,
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic [3:0]          REG_BE,
  input  wire logic [31:0]         REG_WDATA,
  output logic      [31:0]         REG_RDATA,
  // EEPROM configuration load
  input  wire logic                EE_LOAD,
  input  wire logic [7:0]          EE_ADDR,
  input  wire logic [31:0]         EE_DATA,
  // Device mode straps
  input  wire logic [2:0]          MODE_PINS,
  // Multi-purpose pins
  input  wire logic [NUM_PINS-1:0] MPIO_IN,
  output logic      [NUM_PINS-1:0] MPIO_OUT,
  output logic      [NUM_PINS-1:0] MPIO_OE,
  output logic      [NUM_PINS-1:0] MPIO_LEVEL,
  // Function 1 wake status
  input  wire logic                WAKE_STATUS_CLR,
  output logic                     WAKE_STATUS,
  // Function 0 power-down filter
  input  wire logic                PD_REQUEST,
  output logic                     PD_IRQ
);

  localparam int CFG_W = NUM_PINS * FIELD_W;

  // Refuse sizes the register and pin overrides cannot serve
  if (NUM_PINS <= WAKE_PIN || CFG_W > 32) begin : g_bad_pins
    $error("NUM_PINS out of range");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  logic [CFG_W-1:0]  cfg_q;
  logic [7:2]        lc_q;
  logic [2:0]        mode_meta_q;
  logic [2:0]        mode_q;
  logic              wake_q;
  logic [31:0]       tick_cnt_q;
  logic              tick;
  logic [SEC_W-1:0]  sec_q;
  logic [SEC_W-1:0]  filt_limit;
  logic              pd_irq_q;
  logic              host_wr;
  logic              wr_en;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_be;
  logic [1:0]        filt;
  logic              wake_en;
  logic              par_mode;
  logic              wake_act;
  logic [NUM_PINS-1:0] level;

  // EEPROM load wins over a host write in the same cycle
  assign host_wr = REG_SEL && REG_WR;
  assign wr_en   = EE_LOAD || host_wr;
  assign wr_addr = EE_LOAD ? EE_ADDR : REG_ADDR;
  assign wr_data = EE_LOAD ? EE_DATA : REG_WDATA;
  assign wr_be   = EE_LOAD ? 4'hf : REG_BE;

  assign filt     = lc_q[LC_FILT_LO+1:LC_FILT_LO];
  assign wake_en  = lc_q[LC_WAKE_EN];
  assign par_mode = (mode_q == MODE_PAR_A) || (mode_q == MODE_PAR_B);

  // Pin configuration register, byte lanes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= {NUM_PINS{CFG_RESET}};
    end else if (wr_en && wr_addr == PIN_CFG_OFS) begin
      for (int i = 0; i < CFG_W; i++) begin
        if (wr_be[i/8])
          cfg_q[i] <= wr_data[i];
      end
    end
  end

  // Local control bits 7:2 in byte lane 0
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lc_q <= LC_RESET;
    end else if (wr_en && wr_addr == LOCAL_CTRL_OFS && wr_be[0]) begin
      lc_q <= wr_data[7:2];
    end
  end

  // Mode straps come from pins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_meta_q <= 3'h0;
      mode_q      <= 3'h0;
    end else begin
      mode_meta_q <= MODE_PINS;
      mode_q      <= mode_meta_q;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h0;
    end else if (REG_SEL && !REG_WR) begin
      REG_RDATA <= 32'h0;
      if (REG_ADDR == PIN_CFG_OFS) begin
        REG_RDATA[CFG_W-1:0] <= cfg_q;
      end else if (REG_ADDR == LOCAL_CTRL_OFS) begin
        REG_RDATA[LC_MODE_LO+1:LC_MODE_LO] <= mode_q[1:0];
        REG_RDATA[7:2]                     <= lc_q;
        REG_RDATA[LC_MODE2]                <= mode_q[2];
      end
    end
  end

  // Pin cells
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic forced;
    logic wake_mode;
    if (p == PAR_PIN) begin : g_par
      assign forced = par_mode;
    end else if (p == PD_PIN) begin : g_pd
      assign forced = (filt != FILT_OFF);
    end else begin : g_plain
      assign forced = 1'b0;
    end
    assign wake_mode = (p == WAKE_PIN) && wake_en;
    mpio_pin_cell u_cell (
      .clk       (CLK),
      .arst_n    (ARST_N),
      .pad_in    (MPIO_IN[p]),
      .pad_out   (MPIO_OUT[p]),
      .pad_oe    (MPIO_OE[p]),
      .code      (cfg_q[FIELD_W*p+1:FIELD_W*p]),
      .forced    (forced),
      .wake_mode (wake_mode),
      .level     (level[p])
    );
  end

  assign MPIO_LEVEL = level;

  // Pin 2 level is the synchronised raw level while in wake use
  assign wake_act = wake_en && (level[WAKE_PIN] ^ cfg_q[WAKE_POL_BIT]);

  // Sticky wake status; a new event wins over a clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_q <= 1'b0;
    end else if (wake_act) begin
      wake_q <= 1'b1;
    end else if (WAKE_STATUS_CLR) begin
      wake_q <= 1'b0;
    end
  end

  assign WAKE_STATUS = wake_q;

  // One-second tick enable
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_comb begin
    unique case (filt)
      FILT_OFF:  filt_limit = '0;
      FILT_4S:   filt_limit = SEC_W'(FILT_4S_SEC);
      FILT_129S: filt_limit = SEC_W'(FILT_129S_SEC);
      FILT_518S: filt_limit = SEC_W'(FILT_518S_SEC);
    endcase
  end

  // Seconds a power-down request has been held
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sec_q <= '0;
    end else if (!PD_REQUEST || filt == FILT_OFF) begin
      sec_q <= '0;
    end else if (tick && sec_q != filt_limit) begin
      sec_q <= sec_q + SEC_W'(1);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pd_irq_q <= 1'b0;
    end else begin
      pd_irq_q <= PD_REQUEST && (filt != FILT_OFF) &&
                  (sec_q == filt_limit);
    end
  end

  assign PD_IRQ = pd_irq_q;

endmodule // multipurpose_io_config

// >>> mpio_pkg.sv
/*
  Constants for the multi-purpose pin configuration block: register
  offsets, field layout, pin codes and the power-down filter encoding.
  Assumes a 100 MHz core clock.
*/
package mpio_pkg;

  localparam int          NUM_PINS       = 12;
  localparam int          FIELD_W        = 2;
  localparam int          CLK_HZ         = 100_000_000;

  // Register byte offsets
  localparam logic [7:0]  LOCAL_CTRL_OFS = 8'h00;
  localparam logic [7:0]  PIN_CFG_OFS    = 8'h04;

  // Pin field codes
  localparam logic [1:0]  CODE_IN        = 2'h0;
  localparam logic [1:0]  CODE_IN_INV    = 2'h1;
  localparam logic [1:0]  CODE_OUT_LO    = 2'h2;
  localparam logic [1:0]  CODE_OUT_HI    = 2'h3;
  localparam logic [1:0]  CFG_RESET      = 2'h0;

  // Overridden pins
  localparam int          PAR_PIN        = 0;
  localparam int          PD_PIN         = 1;
  localparam int          WAKE_PIN       = 2;
  localparam int          WAKE_POL_BIT   = 4;

  // Device mode codes that enable the parallel port
  localparam logic [2:0]  MODE_PAR_A     = 3'h1;
  localparam logic [2:0]  MODE_PAR_B     = 3'h5;

  // Local control register fields
  localparam int          LC_MODE_LO     = 0;
  localparam int          LC_CLKOUT      = 2;
  localparam int          LC_LANE_LO     = 3;
  localparam int          LC_FILT_LO     = 5;
  localparam int          LC_WAKE_EN     = 7;
  localparam int          LC_MODE2       = 31;
  localparam logic [7:2]  LC_RESET       = 6'h00;

  // Power-down filter setting and its times in seconds
  localparam logic [1:0]  FILT_OFF       = 2'h0;
  localparam logic [1:0]  FILT_4S        = 2'h1;
  localparam logic [1:0]  FILT_129S      = 2'h2;
  localparam logic [1:0]  FILT_518S      = 2'h3;
  localparam int          FILT_4S_SEC    = 4;
  localparam int          FILT_129S_SEC  = 129;
  localparam int          FILT_518S_SEC  = 518;
  localparam int          SEC_W          = 10;

endpackage

// >>> mpio_pin_cell.sv
`timescale 1ns/1ns
/*
  One multi-purpose pin: input synchroniser, code decode, output drive.
  Assumes the pad combines output and enable outside this module.
*/
module mpio_pin_cell
  import mpio_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Pad
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  // Control
  input  wire logic [1:0] code,
  input  wire logic       forced,
  input  wire logic       wake_mode,
  // Internal level
  output logic            level
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pad_in;
      sync_q <= meta_q;
    end
  end

  always_comb begin
    pad_oe  = 1'b0;
    pad_out = 1'b0;
    level   = sync_q;
    if (forced) begin
      pad_oe  = 1'b1;
    end else if (wake_mode) begin
      pad_oe  = 1'b0;
    end else begin
      unique case (code)
        CODE_IN:     level = sync_q;
        CODE_IN_INV: level = ~sync_q;
        CODE_OUT_LO: begin
          pad_oe  = 1'b1;
          pad_out = 1'b0;
        end
        CODE_OUT_HI: begin
          pad_oe  = 1'b1;
          pad_out = 1'b1;
        end
      endcase
    end
  end

endmodule // mpio_pin_cell

// >>> mpio_properties.sv
`timescale 1ns/1ns
/*
  Checker for the multi-purpose pin configuration block.
  Assumes it is bound onto multipurpose_io_config.
*/
module mpio_properties
  import mpio_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)
(
  // Clock, reset and register port
  input wire logic                CLK,
  input wire logic                ARST_N,
  input wire logic                REG_SEL,
  input wire logic                REG_WR,
  input wire logic [7:0]          REG_ADDR,
  input wire logic [3:0]          REG_BE,
  input wire logic [31:0]         REG_WDATA,
  input wire logic                EE_LOAD,
  input wire logic [2:0]          MODE_PINS,
  // Pins and status
  input wire logic [NUM_PINS-1:0] MPIO_IN,
  input wire logic [NUM_PINS-1:0] MPIO_OUT,
  input wire logic [NUM_PINS-1:0] MPIO_OE,
  input wire logic [NUM_PINS-1:0] MPIO_LEVEL,
  input wire logic                WAKE_STATUS_CLR,
  input wire logic                WAKE_STATUS,
  input wire logic                PD_REQUEST,
  input wire logic                PD_IRQ
);
  logic cfg_wr;
  logic lc_wr;
  assign cfg_wr = REG_SEL && REG_WR && !EE_LOAD && REG_ADDR == PIN_CFG_OFS;
  assign lc_wr = REG_SEL && REG_WR && !EE_LOAD &&
                 REG_ADDR == LOCAL_CTRL_OFS && REG_BE[0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  pin_drive_a: assert property (cfg_wr && REG_BE[0] |=>
    MPIO_OE[3] == $past(REG_WDATA[7]) && (!MPIO_OE[3] ||
    MPIO_OUT[3] == $past(REG_WDATA[6]))) else $error("pin 3 drive wrong");
  field_pos_a: assert property (cfg_wr && REG_BE[2] |=>
    MPIO_OE[10] == $past(REG_WDATA[21])) else $error("pin 10 field wrong");
  par_force_a: assert property (
    (MODE_PINS == MODE_PAR_A || MODE_PINS == MODE_PAR_B)[*3] |->
    MPIO_OE[0] && !MPIO_OUT[0]) else $error("pin 0 not forced");
  pd_force_a: assert property (
    lc_wr && REG_WDATA[6:5] != FILT_OFF |=> MPIO_OE[1] && !MPIO_OUT[1])
    else $error("pin 1 not forced");
  wake_pin_a: assert property (lc_wr && REG_WDATA[7] |=> !MPIO_OE[2])
    else $error("pin 2 driven in wake use");
  wake_hold_a: assert property (
    WAKE_STATUS && !WAKE_STATUS_CLR |=> WAKE_STATUS)
    else $error("wake status lost");
  inv_level_a: assert property (
    cfg_wr && REG_BE[0] && REG_WDATA[7:6] == CODE_IN_INV ##1
    (!REG_SEL && !EE_LOAD && $stable(MPIO_IN[3]))[*4] |->
    MPIO_LEVEL[3] == !MPIO_IN[3]) else $error("pin 3 not inverted");
  pd_quiet_a: assert property (!PD_REQUEST [*2] |-> !PD_IRQ)
    else $error("power-down request without cause");
  cover property (WAKE_STATUS ##1 WAKE_STATUS_CLR);
  cover property (PD_IRQ);
  cover property (MPIO_OE[0] && MODE_PINS == MODE_PAR_B);
endmodule // mpio_properties

bind multipurpose_io_config mpio_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .CLK(CLK), .ARST_N(ARST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
  .EE_LOAD(EE_LOAD), .MODE_PINS(MODE_PINS), .MPIO_IN(MPIO_IN),
  .MPIO_OUT(MPIO_OUT), .MPIO_OE(MPIO_OE), .MPIO_LEVEL(MPIO_LEVEL),
  .WAKE_STATUS_CLR(WAKE_STATUS_CLR), .WAKE_STATUS(WAKE_STATUS),
  .PD_REQUEST(PD_REQUEST), .PD_IRQ(PD_IRQ));

// >>> mpio_board.sv
`timescale 1ns/1ns
/*
  Board model for the multi-purpose pins.
  Assumes weak board sources that lose to the block's drivers.
*/
module mpio_board
  import mpio_pkg::*;
(
  // Block side
  input  wire logic [NUM_PINS-1:0] oe,
  input  wire logic [NUM_PINS-1:0] dout,
  // Board sources and resolved wires
  input  wire logic [NUM_PINS-1:0] drive,
  output logic      [NUM_PINS-1:0] pin
);
  assign pin = (oe & dout) | (~oe & drive);
endmodule // mpio_board

// >>> test_multipurpose_io_config.sv
`timescale 1ns/1ns
/*
  Self-checking bench for the multi-purpose pin configuration block.
  Assumes a 100 MHz clock and a short tick for the filter timer.
*/
module test_multipurpose_io_config;
  import mpio_pkg::*;
  localparam int TICK = 10;
  logic                CLK = 1'b0, ARST_N = 1'b0, REG_SEL = 1'b0;
  logic                REG_WR = 1'b0, EE_LOAD = 1'b0, PD_REQUEST = 1'b0;
  logic                WAKE_STATUS_CLR = 1'b0, WAKE_STATUS, PD_IRQ;
  logic [7:0]          REG_ADDR = '0, EE_ADDR = '0;
  logic [3:0]          REG_BE = 4'hf;
  logic [31:0]         REG_WDATA = '0, EE_DATA = '0, REG_RDATA;
  logic [2:0]          MODE_PINS = '0;
  logic [NUM_PINS-1:0] drive = '0, pin, MPIO_OUT, MPIO_OE, MPIO_LEVEL;
  int                  bad_count = 0, cmp_count = 0;
  always #5 CLK = ~CLK;
  multipurpose_io_config #(.TICK_CYCLES(TICK)) dut (.CLK(CLK),
    .ARST_N(ARST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .EE_LOAD(EE_LOAD), .EE_ADDR(EE_ADDR),
    .EE_DATA(EE_DATA), .MODE_PINS(MODE_PINS), .MPIO_IN(pin),
    .MPIO_OUT(MPIO_OUT), .MPIO_OE(MPIO_OE), .MPIO_LEVEL(MPIO_LEVEL),
    .WAKE_STATUS_CLR(WAKE_STATUS_CLR), .WAKE_STATUS(WAKE_STATUS),
    .PD_REQUEST(PD_REQUEST), .PD_IRQ(PD_IRQ));
  mpio_board board (.oe(MPIO_OE), .dout(MPIO_OUT), .drive(drive), .pin(pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict(input bit hang);
    if (hang) bad_count++;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic access(input bit w, input logic [7:0] a,
                        input logic [31:0] d);
    @(negedge CLK);
    REG_SEL = 1'b1;
    REG_WR = w;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_SEL = 1'b0;
    if (!w) check(REG_RDATA, d);
  endtask
  task automatic clear_wake(input logic exp);
    @(negedge CLK);
    WAKE_STATUS_CLR = 1'b1;
    @(negedge CLK);
    WAKE_STATUS_CLR = 1'b0;
    @(negedge CLK);
    check(WAKE_STATUS, exp);
  endtask
  task automatic t_codes;
    logic [23:0] f;
    logic [1:0]  k;
    drive = 12'ha5c;
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < NUM_PINS; n++) f[2*n +: 2] = 2'(n + c);
      access(1'b1, PIN_CFG_OFS, {8'h00, f});
      // Quiet bus after the write so the inversion property can engage
      repeat (4) @(negedge CLK);
      access(1'b0, PIN_CFG_OFS, {8'h00, f});
      repeat (3) @(negedge CLK);
      for (int n = 0; n < NUM_PINS; n++) begin
        k = 2'(n + c);
        check(MPIO_OE[n], k[1]);
        check(k[1] ? MPIO_OUT[n] : MPIO_LEVEL[n], k[0] ^ (!k[1] & drive[n]));
      end
    end
    @(negedge CLK);
    {REG_SEL, REG_WR, REG_ADDR, REG_WDATA} = {2'h3, PIN_CFG_OFS, 32'h0};
    {EE_LOAD, EE_ADDR, EE_DATA} = {1'b1, PIN_CFG_OFS, 32'hffe49c3f};
    @(negedge CLK);
    {REG_SEL, EE_LOAD} = 2'h0;
    access(1'b0, PIN_CFG_OFS, 32'h00e49c3f);
    $display("pin code test done");
  endtask
  task automatic t_par;
    access(1'b1, PIN_CFG_OFS, 32'h00000003);
    for (int i = 0; i < 8; i++) begin
      MODE_PINS = 3'(i);
      repeat (3) @(negedge CLK);
      check({MPIO_OE[0], MPIO_OUT[0]}, (i == 1 || i == 5) ? 2'h2 : 2'h3);
      access(1'b0, LOCAL_CTRL_OFS, {i[2], 29'h0, i[1:0]});
    end
    MODE_PINS = '0;
    $display("mode override test done");
  endtask
  task automatic t_pd;
    int lim[4] = '{0, 4, 129, 518};
    int n;
    access(1'b1, PIN_CFG_OFS, 32'h0000000c);
    for (int s = 0; s < 4; s++) begin
      access(1'b1, LOCAL_CTRL_OFS, 32'(s) << 5);
      check({MPIO_OE[1], MPIO_OUT[1]}, s ? 2'h2 : 2'h3);
      PD_REQUEST = 1'b1;
      for (n = 0; n < (lim[s] + 2) * TICK && !PD_IRQ; n++) @(negedge CLK);
      if (s == 0) check(PD_IRQ, 1'b0);
      else if (!PD_IRQ) give_verdict(1'b1);
      else begin
        check(n >= (lim[s] - 1) * TICK, 1'b1);
        check(n <= lim[s] * TICK + 1, 1'b1);
      end
      PD_REQUEST = 1'b0;
      repeat (2) @(negedge CLK);
      check(PD_IRQ, 1'b0);
    end
    access(1'b1, LOCAL_CTRL_OFS, 32'h0);
    $display("power-down filter test done");
  endtask
  task automatic t_wake;
    drive[2] = 1'b1;
    // Pin 2 plain input held at its active level while wake use is off
    access(1'b1, PIN_CFG_OFS, 32'h00000000);
    repeat (4) @(negedge CLK);
    check(WAKE_STATUS, 1'b0);
    access(1'b1, PIN_CFG_OFS, 32'h00000020);
    check(MPIO_OE[2], 1'b1);
    access(1'b1, LOCAL_CTRL_OFS, 32'h00000080);
    check(MPIO_OE[2], 1'b0);
    repeat (3) @(negedge CLK);
    check(WAKE_STATUS, 1'b1);
    clear_wake(1'b1);
    drive[2] = 1'b0;
    repeat (3) @(negedge CLK);
    clear_wake(1'b0);
    access(1'b1, PIN_CFG_OFS, 32'h00000010);
    repeat (3) @(negedge CLK);
    check(WAKE_STATUS, 1'b1);
    drive[2] = 1'b1;
    repeat (3) @(negedge CLK);
    clear_wake(1'b0);
    access(1'b1, LOCAL_CTRL_OFS, 32'h0);
    $display("wake input test done");
  endtask
  initial begin
    repeat (16) @(negedge CLK);
    ARST_N = 1'b1;
    access(1'b0, PIN_CFG_OFS, 32'h0);
    access(1'b0, 8'h08, 32'h0);
    t_codes;
    t_par;
    t_pd;
    t_wake;
    give_verdict(1'b0);
  end
endmodule // test_multipurpose_io_config
